// [core/smx_pkg.sv]
// package: constants for the stretched external memory access unit
package smx_pkg;
   // ---------------------------------------------------------------
   // special-function register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA_POINTER_LOW  = 8'h82;
   localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
   localparam logic [7:0] ADDR_ALT_POINTER_LOW   = 8'h84;
   localparam logic [7:0] ADDR_ALT_POINTER_HIGH  = 8'h85;
   localparam logic [7:0] ADDR_POINTER_SELECT    = 8'h86;
   localparam logic [7:0] ADDR_CLOCK_STRETCH     = 8'h8e;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int         STRETCH_LSB         = 0;
   localparam int         STRETCH_MSB         = 2;
   localparam int         CONTROL_KEEP_MSB    = 5;
   localparam int         SELECT_BIT          = 0;
   localparam logic [7:0] RESET_CLOCK_STRETCH = 8'h01;
   localparam logic [7:0] RESET_POINTER_BYTE  = 8'h00;
   localparam logic       RESET_SELECT        = 1'b0;

   // ---------------------------------------------------------------
   // timing counts in input clocks, the move base in machine cycles
   // ---------------------------------------------------------------
   localparam int         CLKS_PER_CYCLE      = 4;
   localparam int         ALE_CLKS            = 2;
   localparam int         STROBE_START        = CLKS_PER_CYCLE;
   localparam int         STROBE_MIN_CLKS     = 2;
   localparam int         STROBE_STEP_CLKS    = 4;
   localparam int         MOVE_BASE_CYCLES    = 2;

   typedef enum logic [1:0] {
      SMX_IDLE,
      SMX_FETCH,
      SMX_MOVE
   } smx_state_e;
endpackage : smx_pkg

// [core/smx_phase_if.sv]
// interface: machine-cycle phase carried from the phase generator
`timescale 1ns/10ps
`default_nettype none
interface smx_phase_if;
   logic [1:0] phase;
   logic       cycle_last;

   modport gen (output phase, output cycle_last);
   modport use_phase (input phase, input cycle_last);
endinterface : smx_phase_if
`default_nettype wire

// [core/smx_phase.sv]
// module: machine-cycle phase generator, four clocks per cycle
`timescale 1ns/10ps
`default_nettype none
module smx_phase (
   input  wire logic  i_ref_clk,
   input  wire logic  i_reset,
   smx_phase_if.gen   ph
);
   logic [1:0] count;

   // ---------------------------------------------------------------
   // free-running phase counter
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         count <= 2'h0;
      end else begin
         count <= count + 2'h1; // wraps after four clocks
      end
   end

   assign ph.phase      = count;
   assign ph.cycle_last = (count == 2'(smx_pkg::CLKS_PER_CYCLE - 1));
endmodule : smx_phase
`default_nettype wire

// [core/smx_top.sv]
// module: external program fetch and stretched data move unit
`timescale 1ns/10ps
`default_nettype none
module smx_top (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   // register port from the core
   input  wire logic [7:0]  i_sfr_addr,
   input  wire logic        i_sfr_wr,
   input  wire logic [7:0]  i_sfr_wdata,
   output logic      [7:0]  o_sfr_rdata,
   // program fetch request
   input  wire logic        i_fetch_req,
   input  wire logic [15:0] i_fetch_addr,
   // external data move request
   input  wire logic        i_move_req,
   input  wire logic        i_move_write,
   input  wire logic [7:0]  i_move_wdata,
   // answers to the core
   output logic             o_fetch_ack,
   output logic             o_move_ack,
   output logic             o_done,
   output logic             o_done_fetch,
   output logic      [7:0]  o_rdata,
   output logic             o_busy,
   // external pins
   output logic             o_ale,
   output logic             o_psen_n,
   output logic             o_rd_n,
   output logic             o_wr_n,
   input  wire logic [7:0]  i_address_data_port,
   output logic      [7:0]  o_address_data_port,
   output logic             o_address_data_port_oe,
   output logic      [7:0]  o_high_address_port
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   smx_phase_if ph ();

   logic [7:0]         data_pointer_low;
   logic [7:0]         data_pointer_high;
   logic [7:0]         alt_pointer_low;
   logic [7:0]         alt_pointer_high;
   logic               pointer_selector;
   logic [5:0]         clock_and_stretch_control;

   smx_pkg::smx_state_e state;
   smx_pkg::smx_state_e next_state;
   logic [5:0]         cnt;
   logic [5:0]         next_cnt;
   logic [2:0]         move_stretch;
   logic [2:0]         next_stretch;
   logic [15:0]        addr;
   logic [15:0]        next_addr;
   logic               write_move;
   logic               next_write;
   logic [7:0]         wdata;
   logic [7:0]         next_wdata;
   logic [5:0]         last_cnt;
   logic [5:0]         strobe_clks;
   logic               at_last;
   logic               can_start;
   logic               take_move;
   logic               take_fetch;
   logic [2:0]         stretch_now;
   logic [15:0]        move_pointer;
   logic [5:0]         next_last;
   logic [5:0]         next_strobe;
   logic               next_ale;
   logic               next_psen_n;
   logic               next_rd_n;
   logic               next_wr_n;
   logic [7:0]         next_ad;
   logic               next_ad_oe;

   smx_phase u_phase (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .ph        (ph.gen)
   );

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   assign stretch_now  = clock_and_stretch_control[smx_pkg::STRETCH_MSB:smx_pkg::STRETCH_LSB];
   // the selector bit alone picks the pointer for moves
   assign move_pointer = pointer_selector ? {alt_pointer_high, alt_pointer_low}
                                          : {data_pointer_high, data_pointer_low};

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         data_pointer_low  <= smx_pkg::RESET_POINTER_BYTE;
         data_pointer_high <= smx_pkg::RESET_POINTER_BYTE;
         alt_pointer_low   <= smx_pkg::RESET_POINTER_BYTE;
         alt_pointer_high  <= smx_pkg::RESET_POINTER_BYTE;
      end else if (i_sfr_wr) begin
         case (i_sfr_addr)
            smx_pkg::ADDR_DATA_POINTER_LOW:  data_pointer_low  <= i_sfr_wdata;
            smx_pkg::ADDR_DATA_POINTER_HIGH: data_pointer_high <= i_sfr_wdata;
            smx_pkg::ADDR_ALT_POINTER_LOW:   alt_pointer_low   <= i_sfr_wdata;
            smx_pkg::ADDR_ALT_POINTER_HIGH:  alt_pointer_high  <= i_sfr_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         pointer_selector <= smx_pkg::RESET_SELECT;
      end else if (i_sfr_wr && i_sfr_addr == smx_pkg::ADDR_POINTER_SELECT) begin
         pointer_selector <= i_sfr_wdata[smx_pkg::SELECT_BIT];
      end
   end

   // timer-rate bits are stored for the core but steer nothing here
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         clock_and_stretch_control <= smx_pkg::RESET_CLOCK_STRETCH[5:0];
      end else if (i_sfr_wr && i_sfr_addr == smx_pkg::ADDR_CLOCK_STRETCH) begin
         // writable at any time; a running move keeps its latched copy
         clock_and_stretch_control <= i_sfr_wdata[smx_pkg::CONTROL_KEEP_MSB:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_sfr_rdata <= 8'h00;
      end else begin
         case (i_sfr_addr)
            smx_pkg::ADDR_DATA_POINTER_LOW:  o_sfr_rdata <= data_pointer_low;
            smx_pkg::ADDR_DATA_POINTER_HIGH: o_sfr_rdata <= data_pointer_high;
            smx_pkg::ADDR_ALT_POINTER_LOW:   o_sfr_rdata <= alt_pointer_low;
            smx_pkg::ADDR_ALT_POINTER_HIGH:  o_sfr_rdata <= alt_pointer_high;
            smx_pkg::ADDR_POINTER_SELECT:    o_sfr_rdata <= {7'h00, pointer_selector};
            smx_pkg::ADDR_CLOCK_STRETCH:     o_sfr_rdata <= {2'h0, clock_and_stretch_control};
            default:                         o_sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // access sequencing
   // ---------------------------------------------------------------
   // strobe width: two clocks at stretch zero, else four per step
   function automatic logic [5:0] strobe_of(input logic [2:0] s);
      if (s == 3'h0) begin
         strobe_of = 6'(smx_pkg::STROBE_MIN_CLKS);
      end else begin
         strobe_of = 6'(smx_pkg::STROBE_STEP_CLKS * s);
      end
   endfunction : strobe_of

   // move length: stretch plus two machine cycles
   function automatic logic [5:0] move_last_of(input logic [2:0] s);
      move_last_of = 6'(smx_pkg::CLKS_PER_CYCLE * (s + smx_pkg::MOVE_BASE_CYCLES) - 1);
   endfunction : move_last_of

   assign strobe_clks = strobe_of(move_stretch);
   assign last_cnt    = (state == smx_pkg::SMX_MOVE) ? move_last_of(move_stretch)
                                                     : 6'(smx_pkg::CLKS_PER_CYCLE - 1);
   assign at_last     = (state != smx_pkg::SMX_IDLE) && (cnt == last_cnt);
   // accesses begin only on a machine-cycle boundary
   assign can_start   = ph.cycle_last && (state == smx_pkg::SMX_IDLE || at_last);
   assign take_move   = can_start && i_move_req;
   // a move request wins over a fetch, and a fetch waits out any running stretched move
   assign take_fetch  = can_start && i_fetch_req && !i_move_req;

   always_comb begin
      next_state   = state;
      next_cnt     = cnt + 6'h01;
      next_stretch = move_stretch;
      next_addr    = addr;
      next_write   = write_move;
      next_wdata   = wdata;
      if (take_move) begin
         next_state   = smx_pkg::SMX_MOVE;
         next_cnt     = 6'h00;
         next_stretch = stretch_now;
         next_addr    = move_pointer;
         next_write   = i_move_write;
         next_wdata   = i_move_wdata;
      end else if (take_fetch) begin
         next_state   = smx_pkg::SMX_FETCH;
         next_cnt     = 6'h00;
         next_addr    = i_fetch_addr;
         next_write   = 1'b0;
      end else if (at_last || state == smx_pkg::SMX_IDLE) begin
         next_state   = smx_pkg::SMX_IDLE;
         next_cnt     = 6'h00;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state        <= smx_pkg::SMX_IDLE;
         cnt          <= 6'h00;
         move_stretch <= smx_pkg::RESET_CLOCK_STRETCH[2:0];
         addr         <= 16'h0000;
         write_move   <= 1'b0;
         wdata        <= 8'h00;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         move_stretch <= next_stretch;
         addr         <= next_addr;
         write_move   <= next_write;
         wdata        <= next_wdata;
      end
   end

   // ---------------------------------------------------------------
   // pin values for the coming clock
   // ---------------------------------------------------------------
   assign next_strobe = strobe_of(next_stretch);
   assign next_last   = (next_state == smx_pkg::SMX_MOVE) ? move_last_of(next_stretch)
                                                          : 6'(smx_pkg::CLKS_PER_CYCLE - 1);

   always_comb begin
      next_ale    = 1'b0;
      next_psen_n = 1'b1;
      next_rd_n   = 1'b1;
      next_wr_n   = 1'b1;
      next_ad     = 8'h00;
      next_ad_oe  = 1'b0;
      case (next_state)
         smx_pkg::SMX_FETCH: begin
            if (next_cnt < 6'(smx_pkg::ALE_CLKS)) begin
               next_ale   = 1'b1;
               next_ad    = next_addr[7:0];
               next_ad_oe = 1'b1;
            end else begin
               next_psen_n = 1'b0; // two fixed clocks, never stretched
            end
         end
         smx_pkg::SMX_MOVE: begin
            if (next_cnt < 6'(smx_pkg::ALE_CLKS)) begin
               next_ale   = 1'b1;
               next_ad    = next_addr[7:0];
               next_ad_oe = 1'b1;
            end else if (next_cnt >= 6'(smx_pkg::STROBE_START)) begin
               if (next_cnt < 6'(smx_pkg::STROBE_START) + next_strobe) begin
                  next_rd_n = next_write;
                  next_wr_n = !next_write;
               end
               // write data stays until the move's last clock as hold time
               if (next_write && next_cnt <= next_last) begin
                  next_ad    = next_wdata;
                  next_ad_oe = 1'b1;
               end
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_ale                  <= 1'b0;
         o_psen_n               <= 1'b1;
         o_rd_n                 <= 1'b1;
         o_wr_n                 <= 1'b1;
         o_address_data_port    <= 8'h00;
         o_address_data_port_oe <= 1'b0;
      end else begin
         o_ale                  <= next_ale;
         o_psen_n               <= next_psen_n;
         o_rd_n                 <= next_rd_n;
         o_wr_n                 <= next_wr_n;
         o_address_data_port    <= next_ad;
         o_address_data_port_oe <= next_ad_oe;
      end
   end

   // high byte holds between accesses, as a plain latch port would
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_high_address_port <= 8'h00;
      end else if (next_state != smx_pkg::SMX_IDLE) begin
         o_high_address_port <= next_addr[15:8];
      end
   end

   // ---------------------------------------------------------------
   // answers to the core
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_fetch_ack <= 1'b0;
         o_move_ack  <= 1'b0;
         o_busy      <= 1'b0;
      end else begin
         o_fetch_ack <= take_fetch;
         o_move_ack  <= take_move;
         o_busy      <= (next_state != smx_pkg::SMX_IDLE);
      end
   end

   // read data is caught on the strobe's last clock; the part must be
   // valid by then, there is no ready input to wait longer
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (state == smx_pkg::SMX_FETCH && at_last) begin
         o_rdata <= i_address_data_port;
      end else if (state == smx_pkg::SMX_MOVE && !write_move
                   && cnt == 6'(smx_pkg::STROBE_START) + strobe_clks - 6'h01) begin
         o_rdata <= i_address_data_port;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_done       <= 1'b0;
         o_done_fetch <= 1'b0;
      end else begin
         o_done       <= at_last;
         o_done_fetch <= at_last && (state == smx_pkg::SMX_FETCH);
      end
   end
endmodule : smx_top
`default_nettype wire

// [verif/smx_mem_model.sv]
// model: external memory answering fetches and data moves
`timescale 1ns/10ps
`default_nettype none
module smx_mem_model (
   input  wire logic       i_clk,
   input  wire logic       i_ale,
   input  wire logic       i_psen_n,
   input  wire logic       i_rd_n,
   input  wire logic       i_wr_n,
   input  wire logic       i_slow,
   input  wire logic [7:0] i_bus,
   input  wire logic [7:0] i_high,
   output logic      [7:0] o_data,
   output logic            o_oe
);
   logic [7:0] lo = 8'h00;
   logic [7:0] last = 8'h00;
   logic [7:0] mem [0:65535];
   logic [65535:0] written = '0;
   int         stb = 0;
   wire  [15:0] addr = {i_high, lo};
   // ----------------------------------------------------------
   // latch and store
   // ----------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_ale) lo <= i_bus;
      if (!i_wr_n) begin
         mem[addr]     <= i_bus;
         written[addr] <= 1'b1;
      end
      stb <= (!i_rd_n || !i_psen_n) ? stb + 1 : 0;
      last <= i_bus;
   end
   // ----------------------------------------------------------
   // read drive; slow mode is late by one clock, idle bus toggles
   // ----------------------------------------------------------
   always @* begin
      o_oe = !i_rd_n || !i_psen_n;
      if (o_oe && !(i_slow && stb == 0))
         o_data = written[addr] ? mem[addr] : addr[7:0] ^ addr[15:8] ^ 8'h5a;
      else
         o_data = ~last;
   end
endmodule : smx_mem_model
`default_nettype wire

// [verif/smx_chk.sv]
// checker: bus timing assertions for the access unit
`timescale 1ns/10ps
`default_nettype none
module smx_chk (
   input wire logic       i_ref_clk,
   input wire logic       i_reset,
   input wire logic [7:0] i_sfr_addr,
   input wire logic       i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic       o_fetch_ack,
   input wire logic       o_move_ack,
   input wire logic       o_done,
   input wire logic       o_done_fetch,
   input wire logic       o_ale,
   input wire logic       o_psen_n,
   input wire logic       o_rd_n,
   input wire logic       o_wr_n,
   input wire logic       o_address_data_port_oe
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // ----------------------------------------------------------
   // helpers: stretch shadow, taken at the move's take edge
   // ----------------------------------------------------------
   logic [5:0] ckq;
   logic [2:0] ck_d;
   logic [2:0] s_lat;
   logic [5:0] mv_cnt;
   logic [5:0] stb_cnt;
   wire logic  stb = !o_rd_n || !o_wr_n;
   wire [5:0]  exp_l = 6'(4 * (int'(s_lat) + 2));
   wire [5:0]  exp_w = (s_lat == 3'h0) ? 6'h02 : 6'(4 * int'(s_lat));
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) ckq <= 6'h01;
      else if (i_sfr_wr && i_sfr_addr == 8'h8e) ckq <= i_sfr_wdata[5:0];
   end
   always_ff @(posedge i_ref_clk) begin
      ck_d <= ckq[2:0];
      if (o_move_ack) s_lat <= ck_d;
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) mv_cnt <= 6'h00;
      else if (o_move_ack) mv_cnt <= 6'h01;
      else if (o_done) mv_cnt <= 6'h00;
      else if (mv_cnt != 6'h00) mv_cnt <= mv_cnt + 6'h01;
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !stb) stb_cnt <= 6'h00;
      else stb_cnt <= stb_cnt + 6'h01;
   end
   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   sequence fetch_steps;
      o_ale [*2] ##1 (!o_ale && !o_psen_n && !o_address_data_port_oe) [*2]
         ##1 (o_psen_n && o_done && o_done_fetch);
   endsequence
   sequence addr_phase;
      o_ale && o_address_data_port_oe;
   endsequence
   a_fetch_fixed_shape: assert property (o_fetch_ack |-> fetch_steps)
      else $error("fetch cycle shape wrong");
   a_ale_addr_out: assert property ((o_fetch_ack || o_move_ack) |-> addr_phase [*2] ##1 !o_ale)
      else $error("address phase wrong");
   a_strobe_start: assert property (o_move_ack |-> !stb [*4] ##1 stb)
      else $error("strobe start wrong");
   a_strobe_width: assert property ((!stb && $past(stb)) |-> stb_cnt == exp_w)
      else $error("strobe width wrong");
   a_move_length: assert property ((o_done && !o_done_fetch) |-> mv_cnt == exp_l)
      else $error("move length wrong");
   a_move_done_bound: assert property (o_move_ack |-> ##[8:36] o_done)
      else $error("move never done");
   a_stretch_read: assert property ((i_sfr_addr == 8'h8e && !i_sfr_wr) |=>
      o_sfr_rdata == {2'b00, $past(ckq)}) else $error("stretch readback wrong");
   a_select_zeros: assert property ((i_sfr_addr == 8'h86) |=> o_sfr_rdata[7:1] == 7'h00)
      else $error("selector upper bits set");
endmodule : smx_chk
bind smx_top smx_chk i_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sfr_addr(i_sfr_addr),
   .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
   .o_fetch_ack(o_fetch_ack), .o_move_ack(o_move_ack), .o_done(o_done),
   .o_done_fetch(o_done_fetch), .o_ale(o_ale), .o_psen_n(o_psen_n), .o_rd_n(o_rd_n),
   .o_wr_n(o_wr_n), .o_address_data_port_oe(o_address_data_port_oe));
`default_nettype wire

// [verif/smx_top_tb_top.sv]
// testbench: access unit against the memory model
`timescale 1ns/10ps
`default_nettype none
module smx_top_tb_top;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  sfr_addr = 8'h00;
   logic        sfr_wr = 1'b0;
   logic [7:0]  sfr_wdata = 8'h00;
   logic        fetch_req = 1'b0;
   logic [15:0] fetch_addr = 16'h0000;
   logic        move_req = 1'b0;
   logic        move_write = 1'b0;
   logic [7:0]  move_wdata = 8'h00;
   logic        slow = 1'b0;
   logic [7:0]  sfr_rdata, rdata, port_out, high, mem_data;
   logic        fetch_ack, move_ack, done, done_fetch, busy, ale, psen_n, rd_n, wr_n;
   logic        port_oe, mem_oe;
   int          errors = 0;
   int          num_checks = 0;
   int          cycles = 0;
   wire  [7:0]  bus = port_oe ? port_out : mem_data;
   always #20 ref_clk = ~ref_clk;
   smx_top i_smx_top (.i_ref_clk(ref_clk), .i_reset(reset), .i_sfr_addr(sfr_addr),
      .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
      .i_fetch_req(fetch_req), .i_fetch_addr(fetch_addr), .i_move_req(move_req),
      .i_move_write(move_write), .i_move_wdata(move_wdata), .o_fetch_ack(fetch_ack),
      .o_move_ack(move_ack), .o_done(done), .o_done_fetch(done_fetch), .o_rdata(rdata),
      .o_busy(busy), .o_ale(ale), .o_psen_n(psen_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
      .i_address_data_port(bus), .o_address_data_port(port_out),
      .o_address_data_port_oe(port_oe), .o_high_address_port(high));
   smx_mem_model i_smx_mem_model (.i_clk(ref_clk), .i_ale(ale), .i_psen_n(psen_n),
      .i_rd_n(rd_n), .i_wr_n(wr_n), .i_slow(slow), .i_bus(bus), .i_high(high),
      .o_data(mem_data), .o_oe(mem_oe));
   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic close_out;
      if (errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] mv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction : mv
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      sfr_wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      #1;
      sfr_addr = a;
      @(posedge ref_clk);
      #1;
      chk({8'h00, sfr_rdata}, {8'h00, exp});
   endtask : rd_reg
   // one access; a is the address expected on the pins, er the read data
   task automatic access(input logic m, input logic w, input logic [15:0] a,
                         input logic [7:0] wd, input int s, input logic [7:0] er);
      int n;
      int low;
      int clash;
      n = 0;
      low = 0;
      clash = 0;
      @(posedge ref_clk);
      #1;
      fetch_req = !m;
      fetch_addr = a;
      move_req = m;
      move_write = w;
      move_wdata = wd;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (!(fetch_ack || move_ack) && n < 40);
      chk({15'h0000, ale && port_oe}, 16'h0001);
      chk({high, port_out}, a);
      chk({15'h0000, busy}, 16'h0001);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         fetch_req = 1'b0;
         move_req = 1'b0;
         n++;
         if (!rd_n || !wr_n || !psen_n) low++;
         if (port_oe && mem_oe) clash++;
      end while (!done && n < 40);
      chk(16'(clash), 16'h0000);
      chk({15'h0000, busy}, 16'h0000);
      chk({15'h0000, done_fetch}, {15'h0000, !m});
      chk(16'(n), m ? 16'(4 * (s + 2)) : 16'h0004);
      chk(16'(low), (!m || s == 0) ? 16'h0002 : 16'(4 * s));
      if (!w) chk({8'h00, rdata}, {8'h00, er});
   endtask : access
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_regs;
      rd_reg(8'h8e, 8'h01);
      rd_reg(8'h86, 8'h00);
      wr_reg(8'h86, 8'hff);
      rd_reg(8'h86, 8'h01);
      wr_reg(8'h8e, 8'hff);
      rd_reg(8'h8e, 8'h3f);
      wr_reg(8'h87, 8'hff);
      rd_reg(8'h87, 8'h00);
      wr_reg(8'h86, 8'h00);
      wr_reg(8'h8e, 8'h01);
   endtask : t_regs
   task automatic t_default_move;
      wr_reg(8'h82, 8'ha5);
      wr_reg(8'h83, 8'h12);
      wr_reg(8'h84, 8'h07);
      wr_reg(8'h85, 8'h4e);
      rd_reg(8'h85, 8'h4e);
      access(1'b1, 1'b0, 16'h12a5, 8'h00, 1, mv(16'h12a5));
   endtask : t_default_move
   task automatic t_fetch;
      slow = 1'b1;
      access(1'b0, 1'b0, 16'hbe3c, 8'h00, 0, mv(16'hbe3c));
      access(1'b0, 1'b0, 16'h0001, 8'h00, 0, mv(16'h0001));
      slow = 1'b0;
   endtask : t_fetch
   task automatic t_sweep;
      logic [15:0] a;
      for (int s = 0; s < 8; s++) begin
         a = s[0] ? 16'h4e07 : 16'h12a5;
         wr_reg(8'h8e, 8'(s));
         wr_reg(8'h86, {7'h00, s[0]});
         access(1'b1, 1'b1, a, 8'(8'h30 + s), s, 8'h00);
         access(1'b1, 1'b0, a, 8'h00, s, 8'(8'h30 + s));
      end
   endtask : t_sweep
   task automatic t_change_mid;
      wr_reg(8'h86, 8'h00);
      wr_reg(8'h8e, 8'h02);
      fork
         access(1'b1, 1'b0, 16'h12a5, 8'h00, 2, 8'h36);
         begin
            repeat (6) @(posedge ref_clk);
            wr_reg(8'h8e, 8'h05);
         end
      join
      access(1'b1, 1'b0, 16'h12a5, 8'h00, 5, 8'h36);
   endtask : t_change_mid
   // ----------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      t_regs();
      t_default_move();
      t_fetch();
      t_sweep();
      t_change_mid();
      close_out();
   end
endmodule : smx_top_tb_top
`default_nettype wire
